/* File: shared/oeu_pkg.sv */
/*
 * Constants shared by the output event update logic and its lanes.
 * Assumes an internal 8-bit register port and one zero-crossing detector.
 */
// Operation
// - Two-bit code per channel, ch7 uppermost
// - Code 00 drives 0 on both edges
// - Code 11 drives 1 on both edges
// - Code 01 gives inverted detector state
// - Code 10 gives detector state
// - Enabled outputs follow detector edges per code
// - Disabled outputs ignore detector edges
// - Enabled outputs update on selected alert rising
// - Disabled outputs ignore alert flags
// - Alert trigger drives programmed level
// - Enables and levels reset to zero
// - Per-output mask selects triggering alert channels
package oeu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ZC_CODE_HI   = 8'hE4;
  localparam logic [7:0] ADDR_ZC_UPD_EN    = 8'hE7;
  localparam logic [7:0] ADDR_ALERT_EN     = 8'hE9;
  localparam logic [7:0] ADDR_TRIG_LEVEL   = 8'hEB;
  localparam logic [7:0] ADDR_OUT_STATE    = 8'hEC;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZC_CODE_HI    = 8'h00;
  localparam logic [7:0] RST_ZC_UPD_EN     = 8'h00;
  localparam logic [7:0] RST_ALERT_EN      = 8'h00;
  localparam logic [7:0] RST_TRIG_LEVEL    = 8'h00;
  localparam logic       RST_OUT_LEVEL     = 1'b0;
  localparam int         CODE_W            = 2;
  localparam int         CODE_RISE_BIT     = 1;
  localparam int         CODE_FALL_BIT     = 0;

  // Zero-crossing output codes
  typedef enum logic [1:0] {
    OEU_ZC_LOW    = 2'b00,
    OEU_ZC_INV    = 2'b01,
    OEU_ZC_FOLLOW = 2'b10,
    OEU_ZC_HIGH   = 2'b11
  } oeu_zc_code_t;

endpackage

/* File: shared/oeu_lane_if.sv */
/*
 * Carrier between the output update core and one output lane.
 * Assumes the core drives all events in the ref_clk domain.
 */
`timescale 1ns/1ps
interface oeu_lane_if;
  logic                      zc_rise;
  logic                      zc_fall;
  logic [oeu_pkg::CODE_W-1:0] code;
  logic                      zc_en;
  logic                      alert_hit;
  logic                      alert_en;
  logic                      trig_level;
  logic                      host_wr;
  logic                      host_val;
  logic                      out_q;

  modport core (
    output zc_rise, zc_fall, code, zc_en, alert_hit, alert_en,
    output trig_level, host_wr, host_val,
    input  out_q
  );
  modport lane (
    input  zc_rise, zc_fall, code, zc_en, alert_hit, alert_en,
    input  trig_level, host_wr, host_val,
    output out_q
  );
endinterface

/* File: verilog/oeu_lane.sv */
/*
 * One digital output: picks the next level from alert, zero-crossing
 * and host events. Assumes events arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
module oeu_lane (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Lane carrier
  oeu_lane_if.lane lane
);

  // ----------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------
  wire logic zc_fire;
  wire logic al_fire;
  wire logic zc_val;
  assign zc_fire = lane.zc_en & (lane.zc_rise | lane.zc_fall);
  assign al_fire = lane.alert_en & lane.alert_hit;
  // Rise takes the high code bit, fall the low one
  assign zc_val  = lane.zc_rise ? lane.code[oeu_pkg::CODE_RISE_BIT]
                                : lane.code[oeu_pkg::CODE_FALL_BIT];

  // Output level; alert beats a same-cycle edge, host write is last
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lane.out_q <= oeu_pkg::RST_OUT_LEVEL;
    end else if (al_fire) begin
      lane.out_q <= lane.trig_level;
    end else if (zc_fire) begin
      lane.out_q <= zc_val;
    end else if (lane.host_wr) begin
      lane.out_q <= lane.host_val;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence zc_only_s;
    zc_fire && !al_fire;
  endsequence

  sequence quiet_s;
    !zc_fire && !al_fire && !lane.host_wr;
  endsequence

  zc_low_a: assert property (
    zc_only_s and (lane.code == 2'b00) |=> !lane.out_q)
    else $error("code 00 did not drive low");
  zc_high_a: assert property (
    zc_only_s and (lane.code == 2'b11) |=> lane.out_q)
    else $error("code 11 did not drive high");
  zc_invert_a: assert property (
    zc_only_s and (lane.code == 2'b01) |=> lane.out_q == $past(lane.zc_fall))
    else $error("code 01 did not invert detector");
  zc_follow_a: assert property (
    zc_only_s and (lane.code == 2'b10) |=> lane.out_q == $past(lane.zc_rise))
    else $error("code 10 did not follow detector");
  quiet_hold_a: assert property (
    quiet_s |=> $stable(lane.out_q))
    else $error("output moved without an enabled event");
  alert_level_a: assert property (
    al_fire |=> lane.out_q == $past(lane.trig_level))
    else $error("alert trigger level not applied");
  alert_tie_a: assert property (
    al_fire && zc_fire ##1 quiet_s |=> lane.out_q == $past(lane.trig_level, 2))
    else $error("alert did not win a tie");

endmodule

/* File: verilog/oeu_top.sv */
/*
 * Output event update logic: eight digital outputs updated by
 * zero-crossing edges, selected alert flags or host writes.
 * Assumes synchronous inputs and a single-cycle internal register port.
 */
`timescale 1ns/1ps
module oeu_top #(
  parameter int NUM_OUT = 8
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata_q,
  output logic                        reg_rd_valid_q,
  // Event sources
  input  wire logic                   zero_crossing_state,
  input  wire logic [NUM_OUT-1:0]     alert_flags,
  input  wire logic [NUM_OUT*NUM_OUT-1:0] per_output_event_select_mask,
  input  wire logic [7:0]             zero_cross_output_code_ch0_to_ch3,
  // Direct host update
  input  wire logic                   host_out_wr,
  input  wire logic [NUM_OUT-1:0]     host_out_value,
  // Pins
  output logic      [NUM_OUT-1:0]     digital_output_pin
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] t);
    addr_hit = (a == t);
  endfunction

  wire logic wr_code;
  wire logic wr_zc_en;
  wire logic wr_al_en;
  wire logic wr_level;
  assign wr_code  = reg_wr_en & addr_hit(reg_addr, oeu_pkg::ADDR_ZC_CODE_HI);
  assign wr_zc_en = reg_wr_en & addr_hit(reg_addr, oeu_pkg::ADDR_ZC_UPD_EN);
  assign wr_al_en = reg_wr_en & addr_hit(reg_addr, oeu_pkg::ADDR_ALERT_EN);
  assign wr_level = reg_wr_en & addr_hit(reg_addr, oeu_pkg::ADDR_TRIG_LEVEL);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] zero_cross_output_code_ch4_to_ch7_q;
  logic [7:0] output_zero_cross_update_enable_q;
  logic [7:0] output_alert_trigger_enable_q;
  logic [7:0] output_level_on_alert_trigger_q;

  // Software writes; everything clears so nothing updates by itself
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      zero_cross_output_code_ch4_to_ch7_q <= oeu_pkg::RST_ZC_CODE_HI;
      output_zero_cross_update_enable_q   <= oeu_pkg::RST_ZC_UPD_EN;
      output_alert_trigger_enable_q       <= oeu_pkg::RST_ALERT_EN;
      output_level_on_alert_trigger_q     <= oeu_pkg::RST_TRIG_LEVEL;
    end else begin
      if (wr_code)  zero_cross_output_code_ch4_to_ch7_q <= reg_wdata;
      if (wr_zc_en) output_zero_cross_update_enable_q   <= reg_wdata;
      if (wr_al_en) output_alert_trigger_enable_q       <= reg_wdata;
      if (wr_level) output_level_on_alert_trigger_q     <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  // Unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      oeu_pkg::ADDR_ZC_CODE_HI: rd_mux = zero_cross_output_code_ch4_to_ch7_q;
      oeu_pkg::ADDR_ZC_UPD_EN:  rd_mux = output_zero_cross_update_enable_q;
      oeu_pkg::ADDR_ALERT_EN:   rd_mux = output_alert_trigger_enable_q;
      oeu_pkg::ADDR_TRIG_LEVEL: rd_mux = output_level_on_alert_trigger_q;
      oeu_pkg::ADDR_OUT_STATE:  rd_mux = digital_output_pin;
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Read data lands one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_q    <= 8'h00;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rdata_q    <= reg_rd_en ? rd_mux : reg_rdata_q;
      reg_rd_valid_q <= reg_rd_en;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic               armed_q;
  logic               zc_q;
  logic [NUM_OUT-1:0] alert_q;

  // Edges are ignored on the first cycle after reset so that levels
  // already present at release do not look like fresh events
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      zc_q    <= 1'b0;
      alert_q <= '0;
    end else begin
      armed_q <= 1'b1;
      zc_q    <= zero_crossing_state;
      alert_q <= alert_flags;
    end
  end

  wire logic               zc_rise;
  wire logic               zc_fall;
  wire logic [NUM_OUT-1:0] alert_rise;
  wire logic [15:0]        all_codes;
  assign zc_rise    = armed_q & zero_crossing_state & ~zc_q;
  assign zc_fall    = armed_q & ~zero_crossing_state & zc_q;
  assign alert_rise = {NUM_OUT{armed_q}} & alert_flags & ~alert_q;
  assign all_codes  = {zero_cross_output_code_ch4_to_ch7_q,
                       zero_cross_output_code_ch0_to_ch3};

  // ----------------------------------------------------------------
  // Output lanes
  // ----------------------------------------------------------------
  wire logic [NUM_OUT-1:0] alert_hit;

  generate
    for (genvar k = 0; k < NUM_OUT; k++) begin : g_lane
      oeu_lane_if lif ();
      // Mask bit i lets channel i alerts reach output k
      assign alert_hit[k] = |(alert_rise &
        per_output_event_select_mask[k*NUM_OUT +: NUM_OUT]);
      assign lif.zc_rise    = zc_rise;
      assign lif.zc_fall    = zc_fall;
      assign lif.code       = all_codes[k*oeu_pkg::CODE_W +: oeu_pkg::CODE_W];
      assign lif.zc_en      = output_zero_cross_update_enable_q[k];
      assign lif.alert_hit  = alert_hit[k];
      assign lif.alert_en   = output_alert_trigger_enable_q[k];
      assign lif.trig_level = output_level_on_alert_trigger_q[k];
      assign lif.host_wr    = host_out_wr;
      assign lif.host_val   = host_out_value[k];
      assign digital_output_pin[k] = lif.out_q;

      oeu_lane u_lane (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .lane    (lif.lane)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence en_write_s;
    wr_zc_en ##1 1'b1;
  endsequence

  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> (output_zero_cross_update_enable_q == 8'h00) &&
               (output_alert_trigger_enable_q == 8'h00) &&
               (output_level_on_alert_trigger_q == 8'h00) &&
               (digital_output_pin == 8'h00))
    else $error("enables not cleared by reset");
  code_map_a: assert property (
    wr_code |=> (g_lane[7].lif.code == $past(reg_wdata[7:6])) &&
                (g_lane[4].lif.code == $past(reg_wdata[1:0])))
    else $error("channel code field misplaced");
  zc_enable_a: assert property (
    en_write_s |-> output_zero_cross_update_enable_q == $past(reg_wdata))
    else $error("zero-cross enable write lost");
  mask_gate_a: assert property (
    (per_output_event_select_mask[NUM_OUT-1:0] == '0) |-> !alert_hit[0])
    else $error("masked alert reached output 0");
  // Rises on other channels may still hit output 0, so watch channel 0
  alert_edge_a: assert property (
    alert_flags[0] && per_output_event_select_mask[0] && armed_q
      ##1 alert_flags[0] |-> !alert_rise[0])
    else $error("steady alert flag retriggered");

  // Pin, register and edge checks; they see the lanes only from outside
  sequence zc_idle_s;
    !zc_rise && !zc_fall;
  endsequence

  sequence alert_idle_s;
    alert_rise == '0;
  endsequence

  zc_off_a: assert property (
    (output_zero_cross_update_enable_q == 8'h00) and alert_idle_s and
    !host_out_wr |=> $stable(digital_output_pin))
    else $error("disabled zero-cross edge moved a pin");
  alert_off_a: assert property (
    (output_alert_trigger_enable_q == 8'h00) and zc_idle_s and
    !host_out_wr |=> $stable(digital_output_pin))
    else $error("disabled alert trigger moved a pin");
  level_write_a: assert property (
    wr_level |=> output_level_on_alert_trigger_q == $past(reg_wdata))
    else $error("trigger level write lost");
  first_edge_a: assert property (
    $rose(rst_n) |-> !armed_q && (alert_rise == '0) && !zc_rise)
    else $error("event taken on the release edge");
  // Output 7 on a rising edge takes the top bit of its code field
  zc_lane7_a: assert property (
    zc_rise && output_zero_cross_update_enable_q[7] &&
      !output_alert_trigger_enable_q[7]
      |=> digital_output_pin[7] ==
          $past(zero_cross_output_code_ch4_to_ch7_q[7]))
    else $error("enabled output 7 missed a rising edge");

endmodule

/* File: sim/oeu_load.sv */
/*
 * Model of the outside circuitry that the digital outputs drive.
 * Assumes push-pull pins sampled on ref_clk by a receiving device.
 */
`timescale 1ns/1ps
module oeu_load (
  // Clock
  input  wire logic        ref_clk,
  // Driven pins
  input  wire logic [7:0]  digital_output_pin,
  // Observed activity
  output logic      [15:0] toggles
);
  logic [7:0] last_q;

  // Count level changes mid-cycle, where the pins have settled;
  // one process owns the counter, no timing checks here
  initial begin
    toggles = 16'h0000;
    last_q  = 8'h00;
    forever begin
      @(negedge ref_clk);
      if (digital_output_pin !== last_q) begin
        toggles = toggles + 16'h0001;
      end
      last_q = digital_output_pin;
    end
  end
endmodule

/* File: sim/oeu_top_test.sv */
/*
 * Self-checking bench for the output event update logic.
 * Assumes oeu_top with its default of eight outputs, inputs driven
 * at the falling edge.
 */
`timescale 1ns/1ps
module oeu_top_test;
  logic        ref_clk;
  logic        rst_n;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_q;
  logic        reg_rd_valid_q;
  logic        zc;
  logic [7:0]  alert_flags;
  logic [63:0] ev_mask;
  logic [7:0]  zc_lo;
  logic        host_wr;
  logic [7:0]  host_val;
  logic [7:0]  pins;
  logic [15:0] toggles;
  logic [15:0] codes;
  logic [7:0]  en;
  logic [7:0]  lvl;
  logic [7:0]  rise;
  logic [7:0]  exp_pins;
  logic [7:0]  rdv;
  int          seed;
  int          miscompares;
  int          samples_checked;
  localparam logic [7:0] ADDRS [5] = '{8'hE4, 8'hE7, 8'hE9, 8'hEB, 8'h10};

  // -----------------------------------------------------------------
  // Design and load
  // -----------------------------------------------------------------
  oeu_top i_dut (
    .ref_clk                           (ref_clk),
    .rst_n                             (rst_n),
    .reg_wr_en                         (reg_wr_en),
    .reg_rd_en                         (reg_rd_en),
    .reg_addr                          (reg_addr),
    .reg_wdata                         (reg_wdata),
    .reg_rdata_q                       (reg_rdata_q),
    .reg_rd_valid_q                    (reg_rd_valid_q),
    .zero_crossing_state               (zc),
    .alert_flags                       (alert_flags),
    .per_output_event_select_mask      (ev_mask),
    .zero_cross_output_code_ch0_to_ch3 (zc_lo),
    .host_out_wr                       (host_wr),
    .host_out_value                    (host_val),
    .digital_output_pin                (pins)
  );
  oeu_load i_load (
    .ref_clk            (ref_clk),
    .digital_output_pin (pins),
    .toggles            (toggles)
  );

  // -----------------------------------------------------------------
  // Expectation and bus helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] zc_next(input logic [7:0] old,
      input logic [15:0] c, input logic [7:0] e, input logic r);
    logic [7:0] n;
    n = old;
    for (int k = 0; k < 8; k++) begin
      if (e[k]) n[k] = r ? c[2*k+1] : c[2*k];
    end
    return n;
  endfunction
  function automatic logic [7:0] al_next(input logic [7:0] old,
      input logic [7:0] r, input logic [63:0] m, input logic [7:0] e,
      input logic [7:0] l);
    logic [7:0] n;
    n = old;
    for (int k = 0; k < 8; k++) begin
      if (e[k] && |(m[8*k+:8] & r)) n[k] = l[k];
    end
    return n;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    @(negedge ref_clk);
  endtask
  // Read waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    for (n = 0; n < 4 && reg_rd_valid_q !== 1'b1; n++) @(negedge ref_clk);
    if (n == 4) begin
      miscompares++;
      $display("mismatch at %0t: valid %h expected %h", $time,
               reg_rd_valid_q, 1'b1);
    end
    d = reg_rdata_q;
    @(negedge ref_clk);
  endtask
  task automatic step;
    @(negedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic final_report;
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // -----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Run needs a few hundred cycles; far longer means a hang
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    seed = 85069;
    miscompares = 0;
    samples_checked = 0;
    {reg_wr_en, reg_rd_en, zc, host_wr} = 4'h0;
    {reg_addr, reg_wdata, alert_flags, zc_lo, host_val} = 40'h0;
    ev_mask = 64'h0;
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk(pins, 8'h00);
    foreach (ADDRS[j]) begin
      rd(ADDRS[j], rdv);
      chk(rdv, 8'h00);
    end
    for (int j = 0; j < 4; j++) begin
      lvl = 8'($random(seed));
      wr(ADDRS[j], lvl);
      rd(ADDRS[j], rdv);
      chk(rdv, lvl);
    end
    wr(8'hE9, 8'h00);
    host_val = 8'($random(seed));
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    step();
    exp_pins = host_val;
    chk(pins, exp_pins);
    // Every code on every lane first, then random codes and enables
    for (int i = 0; i < 12; i++) begin
      codes = (i < 4) ? {8{i[1:0]}} : 16'($random(seed));
      en = (i < 4) ? 8'hFF : 8'($random(seed));
      zc_lo = codes[7:0];
      wr(8'hE4, codes[15:8]);
      wr(8'hE7, en);
      for (int h = 0; h < 2; h++) begin
        zc = ~zc;
        step();
        exp_pins = zc_next(exp_pins, codes, en, zc);
        chk(pins, exp_pins);
      end
    end
    wr(8'hE7, 8'h00);
    // Alert triggers: all off, all selected, then random
    for (int i = 0; i < 12; i++) begin
      ev_mask = (i == 1) ? '1 : {$random(seed), $random(seed)};
      en = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      lvl = (i == 1) ? ~exp_pins : 8'($random(seed));
      rise = 8'($random(seed));
      wr(8'hE9, en);
      wr(8'hEB, lvl);
      alert_flags = rise;
      step();
      exp_pins = al_next(exp_pins, rise, ev_mask, en, lvl);
      chk(pins, exp_pins);
      alert_flags = 8'h00;
      step();
      chk(pins, exp_pins);
    end
    // Same-cycle tie, then a later detector edge wins
    ev_mask = '1;
    lvl = ~zc_next(exp_pins, codes, 8'hFF, ~zc);
    wr(8'hE7, 8'hFF);
    wr(8'hE9, 8'hFF);
    wr(8'hEB, lvl);
    zc = ~zc;
    alert_flags = 8'h01;
    step();
    exp_pins = lvl;
    chk(pins, exp_pins);
    alert_flags = 8'h00;
    zc = ~zc;
    step();
    exp_pins = zc_next(exp_pins, codes, 8'hFF, zc);
    chk(pins, exp_pins);
    chk(8'(toggles != 16'h0000), 8'h01);
    rd(oeu_pkg::ADDR_OUT_STATE, rdv);
    chk(rdv, exp_pins);
    final_report();
  end
endmodule
